// ---- rtl/sec_command_logic.sv ----
`timescale 1ns/1ps
// Behaviour
// - Continued clocks read following words
// - Read address wraps top to zero
// - Programming starts on select low, exact count
// - Clock and data ignored while programming
// - Program and erase only when enabled
// - Programming lasts typ 4 ms, max 8 ms
// - Select high during and after programming shows busy low, ready high
// - Start bit during ready floats output, latches
// - Word program writes data, no erase needed
// - Word erase sets word to ones
// - Program all writes data everywhere
// - Erase all sets every bit to one
// - Enable and disable commands set mode
// - Mode changes on select low
// - Low supply cancels writes, forces disable
// - Wrong clock count cancels write commands
// - Command starts at first high data bit
// - Select low means standby once any programming ends
// - Read dummy low bit then sixteen bits
module sec_command_logic
    import sec_pkg::*;
#(
    parameter int P_PROG_CYCLES = SEC_PROG_CYCLES
)
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_clk_en,
    // Serial link
    input wire logic i_chip_select,
    input wire logic i_serial_clock_in,
    input wire logic i_serial_data_in,
    output logic o_data_out,
    output logic o_data_out_oe,
    // Supply monitor
    input wire logic i_low_supply
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        sec_state_type st;
        logic sk_prev;
        logic cs_prev;
        logic [4:0] cnt;
        logic [SEC_SR_W-1:0] sr;
        logic [1:0] op;
        logic [1:0] sub;
        logic [SEC_ADDR_W-1:0] addr;
        logic [SEC_DATA_W-1:0] sh;
        logic [3:0] rcnt;
        logic load;
        logic dummy;
        logic en;
        logic verify;
        logic all;
        logic [SEC_DATA_W-1:0] wdata;
        logic [SEC_ADDR_W:0] idx;
        logic [SEC_TMR_W-1:0] tmr;
        logic dout;
        logic oe;
    } sec_regs_type;

    localparam sec_regs_type REGS_RST = '{st: ST_IDLE, en: SEC_EN_RST, default: '0};
    localparam logic [SEC_TMR_W-1:0] TMR_LAST = SEC_TMR_W'(P_PROG_CYCLES - 1);

    sec_regs_type q;
    sec_regs_type d;
    logic sk_rise;
    logic cs_fall;
    logic go;

    sec_mem_if mem_if ();

    // ---------------------------------------------------------------
    // Word array
    // ---------------------------------------------------------------
    sec_word_array u_array (
        .i_clk_sys (i_clk_sys),
        .mem       (mem_if.store)
    );

    // Whole-array commands step the index, one word per cycle
    assign mem_if.addr = (q.st == ST_BUSY && q.all) ? q.idx[SEC_ADDR_W-1:0] : q.addr;
    assign mem_if.wdata = q.wdata;
    assign mem_if.we = i_clk_en && q.st == ST_BUSY &&
                       (q.all ? !q.idx[SEC_ADDR_W] : q.tmr == '0);

    assign sk_rise = i_serial_clock_in && !q.sk_prev;
    assign cs_fall = q.cs_prev && !i_chip_select;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        d = q;
        go = 1'b0;
        d.sk_prev = i_serial_clock_in;
        d.cs_prev = i_chip_select;
        unique case (q.st)
            ST_IDLE: begin
                if (i_chip_select) begin
                    d.st = ST_HUNT;
                end
            end
            ST_HUNT: begin
                if (!i_chip_select) begin
                    d.st = ST_IDLE;
                end else if (sk_rise && i_serial_data_in) begin
                    d.st = ST_CMD;
                    d.cnt = '0;
                    d.sr = '0;
                    d.verify = 1'b0;
                end
            end
            ST_CMD: begin
                if (!i_chip_select) begin
                    d.st = ST_IDLE;
                    unique case (q.op)
                        SEC_OP_WRITE: begin
                            go = q.cnt == SEC_CNT_DATA;
                            d.all = 1'b0;
                            d.addr = q.sr[SEC_DATA_W +: SEC_ADDR_W];
                            d.wdata = q.sr[SEC_DATA_W-1:0];
                        end
                        SEC_OP_ERASE: begin
                            go = q.cnt == SEC_CNT_ADDR;
                            d.all = 1'b0;
                            d.addr = q.sr[SEC_ADDR_W-1:0];
                            d.wdata = SEC_ERASED;
                        end
                        SEC_OP_EXT: begin
                            d.all = 1'b1;
                            if (q.sub == SEC_SUB_PROG_ALL) begin
                                go = q.cnt == SEC_CNT_DATA;
                                d.wdata = q.sr[SEC_DATA_W-1:0];
                            end else if (q.sub == SEC_SUB_ERASE_ALL) begin
                                go = q.cnt == SEC_CNT_ADDR;
                                d.wdata = SEC_ERASED;
                            end else if (q.cnt >= SEC_CNT_MODE && q.cnt <= SEC_CNT_ADDR) begin
                                d.en = q.sub == SEC_SUB_PROG_EN;
                            end
                        end
                        SEC_OP_READ: begin
                            go = 1'b0;
                        end
                    endcase
                    if (go && q.en) begin
                        d.st = ST_BUSY;
                        d.tmr = '0;
                        d.idx = '0;
                        d.verify = 1'b1;
                    end
                end else if (sk_rise) begin
                    d.sr = {q.sr[SEC_SR_W-2:0], i_serial_data_in};
                    d.cnt = (q.cnt == SEC_CNT_MAX) ? q.cnt : q.cnt + 5'h01;
                    if (q.cnt == SEC_CNT_OP) begin
                        d.op = {q.sr[0], i_serial_data_in};
                    end
                    if (q.cnt == SEC_CNT_SUB) begin
                        d.sub = {q.sr[0], i_serial_data_in};
                    end
                    if (q.cnt == SEC_CNT_ADDR - 5'h01 && q.op == SEC_OP_READ) begin
                        d.st = ST_READ;
                        d.addr = {q.sr[SEC_ADDR_W-2:0], i_serial_data_in};
                        d.load = 1'b1;
                        d.dummy = 1'b1;
                    end
                end
            end
            ST_READ: begin
                if (!i_chip_select) begin
                    d.st = ST_IDLE;
                end else if (q.load) begin
                    d.load = 1'b0;
                    d.sh = mem_if.rdata;
                    d.addr = q.addr + 6'h01;
                end else if (sk_rise) begin
                    d.dout = q.sh[SEC_DATA_W-1];
                    d.sh = {q.sh[SEC_DATA_W-2:0], 1'b0};
                    d.dummy = 1'b0;
                    if (q.dummy) begin
                        d.rcnt = SEC_RD_BITS;
                    end else if (q.rcnt != '0) begin
                        d.rcnt = q.rcnt - 4'h1;
                    end else begin
                        d.dout = mem_if.rdata[SEC_DATA_W-1];
                        d.sh = {mem_if.rdata[SEC_DATA_W-2:0], 1'b0};
                        d.rcnt = SEC_RD_BITS;
                        d.addr = q.addr + 6'h01;
                    end
                end
            end
            ST_BUSY: begin
                // Serial clock and data are not looked at here; select only decides the next state on the last count
                d.tmr = q.tmr + 24'h000001;
                if (q.all && !q.idx[SEC_ADDR_W]) begin
                    d.idx = q.idx + 7'h01;
                end
                if (q.tmr == TMR_LAST) begin
                    d.st = i_chip_select ? ST_HUNT : ST_IDLE;
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase

        // Supply monitor clears the mode and cancels commands and writes; reads go on
        if (i_low_supply) begin
            d.en = 1'b0;
            d.verify = 1'b0;
            if (q.st == ST_BUSY || q.st == ST_CMD) begin
                d.st = ST_IDLE;
            end
        end

        // Output pin
        d.oe = 1'b0;
        if (i_chip_select) begin
            unique case (d.st)
                ST_BUSY: begin
                    d.oe = 1'b1;
                    d.dout = 1'b0;
                end
                ST_HUNT: begin
                    d.oe = d.verify;
                    d.dout = 1'b1;
                end
                ST_READ: begin
                    d.oe = 1'b1;
                    if (q.st != ST_READ) begin
                        d.dout = 1'b0;
                    end
                end
                ST_IDLE, ST_CMD: begin
                    d.oe = 1'b0;
                end
                default: begin
                    d.oe = 1'b0;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q <= REGS_RST;
        end else if (i_clk_en) begin
            q <= d;
        end
    end

    assign o_data_out = q.dout;
    assign o_data_out_oe = q.oe;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b || !i_clk_en);

    a_standby_float: assert property (
        !i_chip_select |=> !o_data_out_oe
    ) else $error("output driven while select low");

    a_busy_shows_low: assert property (
        (q.st == ST_BUSY && q.tmr != TMR_LAST && i_chip_select && !i_low_supply)
        |=> (o_data_out_oe && !o_data_out)
    ) else $error("busy not shown low");

    a_prog_needs_en: assert property (
        $rose(q.st == ST_BUSY) |-> $past(q.en)
    ) else $error("programming started while disabled");

    a_prog_duration: assert property (
        ($fell(q.st == ST_BUSY) && !$past(i_low_supply)) |-> $past(q.tmr) == TMR_LAST
    ) else $error("programming time wrong");

    a_exact_count: assert property (
        $rose(q.st == ST_BUSY) |-> ($past(q.cnt) == SEC_CNT_DATA || $past(q.cnt) == SEC_CNT_ADDR)
    ) else $error("write began on wrong clock count");

    a_addr_wrap: assert property (
        (q.st == ST_READ && q.load && q.addr == SEC_ADDR_TOP && i_chip_select)
        |=> q.addr == '0
    ) else $error("read address did not wrap");

    a_start_floats: assert property (
        (q.st == ST_HUNT && q.verify && i_chip_select && sk_rise && i_serial_data_in && !i_low_supply)
        |=> (q.st == ST_CMD && !o_data_out_oe)
    ) else $error("start bit during ready not taken");

    a_low_supply: assert property (
        i_low_supply |=> (!q.en && q.st != ST_BUSY)
    ) else $error("low supply did not disable");

    a_mode_on_fall: assert property (
        $rose(q.en) |-> $past(q.st == ST_CMD && cs_fall)
    ) else $error("mode changed outside select fall");

    a_dummy_low: assert property (
        $rose(q.st == ST_READ) |-> (o_data_out_oe && !o_data_out) ##1 (q.st != ST_READ || !o_data_out)
    ) else $error("dummy bit not low");

    a_busy_ignores: assert property (
        (q.st == ST_BUSY) |=> (q.cnt == $past(q.cnt) && q.sr == $past(q.sr))
    ) else $error("link activity taken while busy");

    a_standby_state: assert property (
        (!i_chip_select && q.st == ST_HUNT) |=> q.st == ST_IDLE
    ) else $error("standby not entered");

    a_ready_high: assert property (
        (q.st == ST_HUNT && q.verify) |-> (o_data_out_oe && o_data_out)
    ) else $error("ready not shown high");

    a_hunt_floats: assert property (
        (q.st == ST_HUNT && !q.verify) |-> !o_data_out_oe
    ) else $error("output driven while waiting for start bit");

    // Own reset gate: the default one would hide the frozen cycles
    a_freeze_holds: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b) !i_clk_en |=> q == $past(q)
    ) else $error("state moved while clock enable low");

endmodule

// ---- rtl/sec_pkg.sv ----
package sec_pkg;

    // ---------------------------------------------------------------
    // Array geometry
    // ---------------------------------------------------------------
    localparam int SEC_ADDR_W = 6;
    localparam int SEC_DATA_W = 16;
    localparam int SEC_WORDS = 64;
    localparam int SEC_SR_W = 24;
    localparam logic [SEC_ADDR_W-1:0] SEC_ADDR_TOP = 6'h3f;
    localparam logic [SEC_DATA_W-1:0] SEC_ERASED = 16'hffff;

    // ---------------------------------------------------------------
    // Command encodings
    // ---------------------------------------------------------------
    localparam logic [1:0] SEC_OP_EXT = 2'h0;
    localparam logic [1:0] SEC_OP_WRITE = 2'h1;
    localparam logic [1:0] SEC_OP_READ = 2'h2;
    localparam logic [1:0] SEC_OP_ERASE = 2'h3;
    localparam logic [1:0] SEC_SUB_PROG_DIS = 2'h0;
    localparam logic [1:0] SEC_SUB_PROG_ALL = 2'h1;
    localparam logic [1:0] SEC_SUB_ERASE_ALL = 2'h2;
    localparam logic [1:0] SEC_SUB_PROG_EN = 2'h3;

    // ---------------------------------------------------------------
    // Bit counts after the start bit
    // ---------------------------------------------------------------
    localparam logic [4:0] SEC_CNT_OP = 5'h01;
    localparam logic [4:0] SEC_CNT_SUB = 5'h03;
    localparam logic [4:0] SEC_CNT_MODE = 5'h04;
    localparam logic [4:0] SEC_CNT_ADDR = 5'h08;
    localparam logic [4:0] SEC_CNT_DATA = 5'h18;
    localparam logic [4:0] SEC_CNT_MAX = 5'h1f;
    localparam logic [3:0] SEC_RD_BITS = 4'hf;

    // ---------------------------------------------------------------
    // Timing and reset values
    // ---------------------------------------------------------------
    localparam int SEC_CLK_KHZ = 10000;
    localparam int SEC_PROG_TYP_US = 4000;
    localparam int SEC_PROG_MAX_US = 8000;
    localparam int SEC_PROG_CYCLES = (SEC_PROG_TYP_US * SEC_CLK_KHZ) / 1000;
    localparam int SEC_TMR_W = 24;
    localparam logic SEC_EN_RST = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HUNT,
        ST_CMD,
        ST_READ,
        ST_BUSY
    } sec_state_type;

endpackage

// ---- rtl/sec_mem_if.sv ----
`timescale 1ns/1ps
interface sec_mem_if;
    import sec_pkg::*;
    logic [SEC_ADDR_W-1:0] addr;
    logic [SEC_DATA_W-1:0] wdata;
    logic [SEC_DATA_W-1:0] rdata;
    logic we;
    modport ctrl (output addr, output wdata, output we, input rdata);
    modport store (input addr, input wdata, input we, output rdata);
endinterface

// ---- rtl/sec_word_array.sv ----
`timescale 1ns/1ps
module sec_word_array
    import sec_pkg::*;
(
    // Clock
    input wire logic i_clk_sys,
    // Port
    sec_mem_if.store mem
);
    logic [SEC_DATA_W-1:0] words [SEC_WORDS];

    always_ff @(posedge i_clk_sys) begin
        if (mem.we) begin
            words[mem.addr] <= mem.wdata;
        end
    end

    assign mem.rdata = words[mem.addr];
endmodule

// ---- verif/sec_host_model.sv ----
`timescale 1ns/1ps
module sec_host_model (
    // Clock
    input wire logic i_clk_sys,
    // Device output
    input wire logic i_data_out,
    input wire logic i_data_out_oe,
    // Serial link
    output logic o_chip_select,
    output logic o_serial_clock_in,
    output logic o_serial_data_in
);
    // A floating output reads as the opposite of the device's data out bit
    logic do_line;
    assign do_line = i_data_out_oe ? i_data_out : !i_data_out;

    initial begin
        o_chip_select = 1'h0;
        o_serial_clock_in = 1'h0;
        o_serial_data_in = 1'h0;
    end

    // One serial clock, low phase of random length; returns data out after the rise
    task automatic tick(input logic d, output logic q);
        @(posedge i_clk_sys);
        #1;
        o_serial_data_in = d;
        o_serial_clock_in = 1'h0;
        repeat (2 + $urandom_range(0, 1)) @(posedge i_clk_sys);
        #1;
        o_serial_clock_in = 1'h1;
        repeat (2) @(posedge i_clk_sys);
        #1;
        q = do_line;
    endtask

    task automatic shift(input logic [31:0] v, input int n, output logic q);
        for (int k = n - 1; k >= 0; k--) begin
            tick(v[k], q);
        end
    endtask

    task automatic begin_cmd(output logic oe_after);
        logic q;
        @(posedge i_clk_sys);
        #1;
        o_chip_select = 1'h1;
        repeat (2) @(posedge i_clk_sys);
        #1;
        for (int k = 0; k < 400 && i_data_out_oe && !do_line; k++) begin
            tick(1'h0, q);
        end
        repeat ($urandom_range(0, 3)) tick(1'h0, q);
        tick(1'h1, q);
        oe_after = i_data_out_oe;
    endtask

    // Deselect; a stray clock with data high must be ignored
    task automatic end_cmd();
        @(posedge i_clk_sys);
        #1;
        o_chip_select = 1'h0;
        o_serial_clock_in = 1'h0;
        o_serial_data_in = 1'h1;
        @(posedge i_clk_sys);
        #1;
        o_serial_clock_in = 1'h1;
        repeat (2) @(posedge i_clk_sys);
        #1;
        o_serial_clock_in = 1'h0;
        o_serial_data_in = 1'h0;
        @(posedge i_clk_sys);
        #1;
    endtask

    task automatic status(output logic [1:0] st);
        @(posedge i_clk_sys);
        #1;
        o_chip_select = 1'h1;
        repeat (2) @(posedge i_clk_sys);
        #1;
        st = {i_data_out_oe, do_line};
    endtask

    // Verify by holding select and clocking zeros, or by reselecting
    task automatic poll(input logic resel, output logic [1:0] st);
        logic q;
        st = 2'h0;
        for (int k = 0; k < 300 && st !== 2'h3; k++) begin
            if (resel) begin
                end_cmd();
                status(st);
            end else begin
                tick(1'h0, q);
                st = {i_data_out_oe, q};
            end
        end
    endtask
endmodule

// ---- verif/sec_command_logic_bench.sv ----
`timescale 1ns/1ps
module sec_command_logic_bench;
    import sec_pkg::*;

    localparam int P_PROG = 100;

    logic clk_sys = 1'h0;
    logic rst_b;
    logic clk_en;
    logic low_supply;
    logic chip_select;
    logic serial_clock_in;
    logic serial_data_in;
    logic data_out;
    logic data_out_oe;
    logic [SEC_DATA_W-1:0] ref_mem [SEC_WORDS];
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;

    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;

    sec_command_logic #(.P_PROG_CYCLES(P_PROG)) i_sec_command_logic (
        .i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_clk_en(clk_en),
        .i_chip_select(chip_select), .i_serial_clock_in(serial_clock_in),
        .i_serial_data_in(serial_data_in), .o_data_out(data_out),
        .o_data_out_oe(data_out_oe), .i_low_supply(low_supply)
    );

    sec_host_model i_sec_host_model (
        .i_clk_sys(clk_sys), .i_data_out(data_out), .i_data_out_oe(data_out_oe),
        .o_chip_select(chip_select), .o_serial_clock_in(serial_clock_in),
        .o_serial_data_in(serial_data_in)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Bits after the start bit, right aligned: opcode, address, data
    function automatic logic [31:0] frame(logic [1:0] op, logic [5:0] a, logic [15:0] d);
        return {8'h00, op, a, d};
    endfunction

    task automatic run_cmd(input logic [31:0] v, input int n, input logic busy);
        logic oe0;
        logic q;
        logic [1:0] st;
        int t0;
        i_sec_host_model.begin_cmd(oe0);
        check("start_float", oe0, 1'h0);
        i_sec_host_model.shift(v, n, q);
        check("cmd_float", data_out_oe, 1'h0);
        i_sec_host_model.end_cmd();
        check("standby_float", data_out_oe, 1'h0);
        t0 = cyc;
        i_sec_host_model.status(st);
        if (busy) begin
            check("busy", st, 2'h2);
            i_sec_host_model.poll(1'($urandom_range(0, 1)), st);
            check("ready", st, 2'h3);
            check("prog_time", (cyc - t0 >= P_PROG / 2) && (cyc - t0 <= 2 * P_PROG), 1'h1);
            if (st !== 2'h3) wrap_up();
        end else begin
            check("no_busy", st[1], 1'h0);
        end
        i_sec_host_model.end_cmd();
    endtask

    task automatic read_run(input logic [5:0] a, input int words);
        logic oe0;
        logic q;
        logic [15:0] got;
        logic [5:0] idx;
        i_sec_host_model.begin_cmd(oe0);
        i_sec_host_model.shift(frame(SEC_OP_READ, a, 16'h0) >> 16, 8, q);
        check("dummy_bit", {data_out_oe, q}, 2'h2);
        idx = a;
        for (int w = 0; w < words; w++) begin
            for (int b = 15; b >= 0; b--) begin
                i_sec_host_model.tick(1'h0, q);
                got[b] = q;
            end
            check("read_word", got, ref_mem[idx]);
            idx = idx + 6'h01;
        end
        i_sec_host_model.end_cmd();
        check("read_float", data_out_oe, 1'h0);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [15:0] d;
        logic [5:0] a;
        logic [31:0] enable_cmd;
        int kind;
        logic q;
        logic [1:0] st;
        void'($urandom(32'h7b347f87));
        enable_cmd = frame(SEC_OP_EXT, {SEC_SUB_PROG_EN, 4'h0}, 16'h0) >> 20;
        rst_b = 1'h0;
        clk_en = 1'h1;
        low_supply = 1'h0;
        repeat (2) @(posedge clk_sys);
        #1;
        rst_b = 1'h1;
        run_cmd(frame(SEC_OP_EXT, {SEC_SUB_ERASE_ALL, 4'h0}, 16'h0) >> 16, 8, 1'h0);
        run_cmd(enable_cmd, 4, 1'h0);
        d = 16'($urandom);
        run_cmd(frame(SEC_OP_EXT, {SEC_SUB_PROG_ALL, 4'($urandom)}, d), 24, 1'h1);
        foreach (ref_mem[i]) ref_mem[i] = d;
        read_run(6'($urandom), 3);
        run_cmd(frame(SEC_OP_EXT, {SEC_SUB_ERASE_ALL, 4'($urandom)}, 16'h0) >> 16, 8, 1'h1);
        foreach (ref_mem[i]) ref_mem[i] = SEC_ERASED;
        read_run(6'h00, SEC_WORDS + 1);
        for (int i = 0; i < 16; i++) begin
            a = (i < 2) ? (i[0] ? SEC_ADDR_TOP : 6'h00) : 6'($urandom);
            d = 16'($urandom);
            kind = $urandom_range(0, 3);
            case (kind)
                0: begin
                    run_cmd(frame(SEC_OP_WRITE, a, d), 24, 1'h1);
                    ref_mem[a] = d;
                end
                1: begin
                    run_cmd(frame(SEC_OP_ERASE, a, d) >> 16, 8, 1'h1);
                    ref_mem[a] = SEC_ERASED;
                end
                2: run_cmd(frame(SEC_OP_WRITE, a, d) << 1, 25, 1'h0);
                default: run_cmd(frame(SEC_OP_ERASE, a, d) >> 17, 7, 1'h0);
            endcase
            read_run(a, 2);
        end
        a = 6'($urandom);
        run_cmd(frame(SEC_OP_EXT, {SEC_SUB_PROG_DIS, 4'h0}, 16'h0) >> 16, 8, 1'h0);
        run_cmd(frame(SEC_OP_WRITE, a, 16'h5a5a), 24, 1'h0);
        run_cmd(enable_cmd, 4, 1'h0);
        // Rewrite a word with its own value, freeze the busy phase, then cut it by low supply
        i_sec_host_model.begin_cmd(q);
        i_sec_host_model.shift(frame(SEC_OP_WRITE, a ^ 6'h01, ref_mem[a ^ 6'h01]), 24, q);
        i_sec_host_model.end_cmd();
        i_sec_host_model.status(st);
        clk_en = 1'h0;
        repeat (2 * P_PROG) @(posedge clk_sys);
        #1;
        check("frozen_busy", {data_out_oe, data_out}, 2'h2);
        clk_en = 1'h1;
        low_supply = 1'h1;
        repeat (3) @(posedge clk_sys);
        #1;
        low_supply = 1'h0;
        check("abort_busy", data_out_oe, 1'h0);
        i_sec_host_model.end_cmd();
        run_cmd(frame(SEC_OP_WRITE, a, 16'ha5a5), 24, 1'h0);
        read_run(a, 1);
        run_cmd(enable_cmd, 4, 1'h0);
        run_cmd(frame(SEC_OP_WRITE, a, 16'h0f0f), 24, 1'h1);
        ref_mem[a] = 16'h0f0f;
        read_run(a, 1);
        run_cmd(frame(SEC_OP_EXT, {SEC_SUB_PROG_DIS, 4'h0}, 16'h0) >> 16, 8, 1'h0);
        wrap_up();
    end

    initial begin
        repeat (100000) @(posedge clk_sys);
        err_count++;
        wrap_up();
    end
endmodule
